// ---- logic/csrb_regs.vh ----
// register map, field layout and response constants of the settings block
`ifndef CSRB_REGS_VH
`define CSRB_REGS_VH

// ============================================================
// register byte offsets
`define CSRB_OFF_SEC      8'h00
`define CSRB_OFF_CLKDIV   8'h04
`define CSRB_OFF_DACCFG   8'h08
`define CSRB_OFF_EDGECFG  8'h0C
`define CSRB_OFF_VID      8'h10
`define CSRB_OFF_PID      8'h14
`define CSRB_OFF_PWRATTR  8'h18
`define CSRB_OFF_CURHALF  8'h1C
`define CSRB_OFF_STATUS   8'h20
`define CSRB_OFF_CLEAR    8'h24
`define CSRB_OFF_INTEN    8'h28

// ============================================================
// reset values
`define CSRB_RST_SEC      2'h0
`define CSRB_RST_CLKDIV   5'h00
`define CSRB_RST_DACCFG   8'h00
`define CSRB_RST_EDGECFG  8'h00
`define CSRB_RST_VID      16'h0000
`define CSRB_RST_PID      16'h0000
`define CSRB_RST_PWRATTR  8'h00
`define CSRB_RST_CURHALF  8'h00

// ============================================================
// field positions
`define CSRB_CLKEN_BIT    8
`define CSRB_NEG_BIT      6
`define CSRB_POS_BIT      5
`define CSRB_EDGE_MASK    8'h7C
`define CSRB_ST_EDGE      0
`define CSRB_ST_DONE      1
`define CSRB_ST_UNSUP     2
`define CSRB_ST_W         3

// ============================================================
// response layout
`define CSRB_ECHO         8'hB0
`define CSRB_OK           8'h00
`define CSRB_UNSUP        8'h01
`define CSRB_SUB_CHIP     8'h00
`define CSRB_STRUCT_LEN   8'h0E
`define CSRB_LAST_IDX     6'h3F
`define CSRB_RESP_SLVERR  2'h2
`define CSRB_RESP_OKAY    2'h0

`endif

// ---- logic/csrb_edge.v ----
// input synchroniser and edge detector for the interrupt detection pin
`default_nettype none

module csrb_edge (
	input  wire aclk,
	input  wire aresetn,
	input  wire ce,
	input  wire pin_in,
	output reg  rise_r,
	output reg  fall_r
);

	reg sync1_r;
	reg sync2_r;
	reg sync3_r;
	reg stable_r;

	// ============================================================
	// three stages; a change counts when stages two and three agree
	always @(posedge aclk) begin
		if (!aresetn) begin
			sync1_r  <= 1'b0;
			sync2_r  <= 1'b0;
			sync3_r  <= 1'b0;
			stable_r <= 1'b0;
			rise_r   <= 1'b0;
			fall_r   <= 1'b0;
		end else if (ce) begin
			sync1_r <= pin_in;
			sync2_r <= sync1_r;
			sync3_r <= sync2_r;
			rise_r  <= 1'b0;
			fall_r  <= 1'b0;
			if (sync2_r == sync3_r && sync3_r != stable_r) begin
				stable_r <= sync3_r;
				rise_r   <= sync3_r;
				fall_r   <= ~sync3_r;
			end
		end
	end

endmodule

`default_nettype wire

// ---- logic/csrb_clkdiv.v ----
// clock output divider
`default_nettype none

module csrb_clkdiv (
	input  wire       aclk,
	input  wire       aresetn,
	input  wire       ce,
	input  wire       en,
	input  wire [4:0] div,
	output reg        clk_out_r
);

	reg [4:0] cnt_r;

	// ============================================================
	// toggles every div+1 cycles; a zero divider parks the pin low
	always @(posedge aclk) begin
		if (!aresetn) begin
			cnt_r     <= 5'h00;
			clk_out_r <= 1'b0;
		end else if (ce) begin
			if (!en || div == 5'h00) begin
				cnt_r     <= 5'h00;
				clk_out_r <= 1'b0;
			end else if (cnt_r >= div) begin
				cnt_r     <= 5'h00;
				clk_out_r <= ~clk_out_r;
			end else begin
				cnt_r <= cnt_r + 5'h01;
			end
		end
	end

endmodule

`default_nettype wire

// ---- logic/csrb_top.v ----
// chip settings report builder with its register bus slave
//
// How it works
// - response byte 0 echoes 0xB0, byte 1 reports success 0x00
// - byte 4 bits 1-0 report configuration security state
// - byte 5 bits 4-0 hold clock divider; divided clock drives output pin
// - byte 6 bits 7-6 encode DAC reference level
// - byte 6 bit 5 picks internal reference (1) or supply (0) for DAC
// - byte 6 bits 4-0 hold the DAC power-up value
// - byte 7 bit 6 lets falling edges set the detection flag
// - byte 7 bit 5 lets rising edges set the detection flag
// - byte 7 bits 4-3 encode ADC reference level
// - byte 7 bit 2 reports reference: 1 supply, 0 internal reference
// - bytes 8 and 9 carry vendor id, low byte first
// - bytes 10 and 11 carry product id, low byte first
// - byte 12 carries the power attributes value
// - byte 13 holds half the requested supply current in mA
//
// Decided for this implementation: the placing of the registers and the AXI4-Lite interface to the registers.
`default_nettype none
`include "csrb_regs.vh"

module csrb_top (
	input  wire        aclk,
	input  wire        aresetn,
	input  wire        ce,
	input  wire [7:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [7:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	input  wire        req_valid,
	input  wire [7:0]  req_sub,
	output reg         rsp_valid,
	output reg  [5:0]  rsp_idx,
	output reg  [7:0]  rsp_data,
	output reg         rsp_last,
	input  wire        int_pin,
	output wire        clk_out,
	output reg         irq
);

	localparam ST_IDLE = 1'b0;
	localparam ST_SEND = 1'b1;

	// settings
	reg  [1:0]  sec_r;
	reg  [4:0]  clkdiv_r;
	reg         clken_r;
	reg  [7:0]  daccfg_r;
	reg  [7:0]  edgecfg_r;
	reg  [15:0] vid_r;
	reg  [15:0] pid_r;
	reg  [7:0]  pwrattr_r;
	reg  [7:0]  curhalf_r;
	reg  [`CSRB_ST_W-1:0] status_r;
	reg  [`CSRB_ST_W-1:0] status_nxt;
	reg  [`CSRB_ST_W-1:0] inten_r;
	reg  [`CSRB_ST_W-1:0] clr_pulse;

	// bus state
	reg         aw_have_r;
	reg         w_have_r;
	reg  [7:0]  waddr_r;
	reg  [31:0] wdata_r;
	reg  [3:0]  wstrb_r;
	reg  [31:0] rd_val;
	reg         rd_err;
	reg         wr_err;
	wire        wr_go;

	// responder
	reg         state_r;
	reg  [5:0]  idx_r;
	reg         unsup_r;
	reg  [7:0]  byte_val;
	wire        edge_rise;
	wire        edge_fall;
	wire        edge_hit;

	// ============================================================
	// submodules
	csrb_edge u_edge (
		.aclk    (aclk),
		.aresetn (aresetn),
		.ce      (ce),
		.pin_in  (int_pin),
		.rise_r  (edge_rise),
		.fall_r  (edge_fall)
	);

	csrb_clkdiv u_div (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.ce        (ce),
		.en        (clken_r),
		.div       (clkdiv_r),
		.clk_out_r (clk_out)
	);

	assign edge_hit = (edge_fall & edgecfg_r[`CSRB_NEG_BIT])
		| (edge_rise & edgecfg_r[`CSRB_POS_BIT]);

	// ============================================================
	// byte-lane merge for register writes
	function [15:0] merge;
		input [15:0] old;
		input [15:0] nw;
		input [1:0]  strb;
		integer i;
		begin
			merge = old;
			for (i = 0; i < 2; i = i + 1) begin
				if (strb[i]) begin
					merge[i*8 +: 8] = nw[i*8 +: 8];
				end
			end
		end
	endfunction

	// ============================================================
	// response byte content
	always @* begin
		byte_val = 8'h00;
		case (idx_r)
		6'd0: byte_val = `CSRB_ECHO;
		6'd1: byte_val = unsup_r ? `CSRB_UNSUP : `CSRB_OK;
		6'd2: byte_val = unsup_r ? 8'h00 : `CSRB_STRUCT_LEN;
		6'd4: byte_val = unsup_r ? 8'h00 : {6'h00, sec_r};
		6'd5: byte_val = unsup_r ? 8'h00 : {3'h0, clkdiv_r};
		6'd6: byte_val = unsup_r ? 8'h00 : daccfg_r;
		6'd7: byte_val = unsup_r ? 8'h00
			: (edgecfg_r & `CSRB_EDGE_MASK);
		6'd8: byte_val = unsup_r ? 8'h00 : vid_r[7:0];
		6'd9: byte_val = unsup_r ? 8'h00 : vid_r[15:8];
		6'd10: byte_val = unsup_r ? 8'h00 : pid_r[7:0];
		6'd11: byte_val = unsup_r ? 8'h00 : pid_r[15:8];
		6'd12: byte_val = unsup_r ? 8'h00 : pwrattr_r;
		6'd13: byte_val = unsup_r ? 8'h00 : curhalf_r;
		default: byte_val = 8'h00;
		endcase
	end

	// ============================================================
	// responder: one byte per cycle, 64 bytes per request
	always @(posedge aclk) begin
		if (!aresetn) begin
			state_r   <= ST_IDLE;
			idx_r     <= 6'h00;
			unsup_r   <= 1'b0;
			rsp_valid <= 1'b0;
			rsp_idx   <= 6'h00;
			rsp_data  <= 8'h00;
			rsp_last  <= 1'b0;
		end else if (ce) begin
			rsp_valid <= 1'b0;
			rsp_last  <= 1'b0;
			case (state_r)
			ST_IDLE: begin
				// requests arriving mid-report are dropped
				if (req_valid) begin
					unsup_r <= (req_sub != `CSRB_SUB_CHIP);
					idx_r   <= 6'h00;
					state_r <= ST_SEND;
				end
			end
			ST_SEND: begin
				rsp_valid <= 1'b1;
				rsp_idx   <= idx_r;
				rsp_data  <= byte_val;
				rsp_last  <= (idx_r == `CSRB_LAST_IDX);
				idx_r     <= idx_r + 6'h01;
				if (idx_r == `CSRB_LAST_IDX) begin
					state_r <= ST_IDLE;
				end
			end
			default: state_r <= ST_IDLE;
			endcase
		end
	end

	// ============================================================
	// status: a new event wins over a clear in the same cycle
	always @* begin
		clr_pulse = {`CSRB_ST_W{1'b0}};
		if (wr_go && waddr_r == `CSRB_OFF_CLEAR && wstrb_r[0]) begin
			clr_pulse = wdata_r[`CSRB_ST_W-1:0];
		end
		status_nxt = status_r & ~clr_pulse;
		if (edge_hit) begin
			status_nxt[`CSRB_ST_EDGE] = 1'b1;
		end
		if (state_r == ST_SEND && idx_r == `CSRB_LAST_IDX) begin
			status_nxt[`CSRB_ST_DONE] = 1'b1;
			status_nxt[`CSRB_ST_UNSUP] = unsup_r;
		end
	end

	// ============================================================
	// register bus: write side
	assign wr_go = aw_have_r & w_have_r & ~s_axi_bvalid;

	always @* begin
		case (waddr_r)
		`CSRB_OFF_SEC, `CSRB_OFF_CLKDIV, `CSRB_OFF_DACCFG,
		`CSRB_OFF_EDGECFG, `CSRB_OFF_VID, `CSRB_OFF_PID,
		`CSRB_OFF_PWRATTR, `CSRB_OFF_CURHALF, `CSRB_OFF_CLEAR,
		`CSRB_OFF_INTEN: wr_err = 1'b0;
		default: wr_err = 1'b1;
		endcase
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_r     <= 1'b0;
			w_have_r      <= 1'b0;
			waddr_r       <= 8'h00;
			wdata_r       <= 32'h0000_0000;
			wstrb_r       <= 4'h0;
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `CSRB_RESP_OKAY;
			sec_r         <= `CSRB_RST_SEC;
			clkdiv_r      <= `CSRB_RST_CLKDIV;
			clken_r       <= 1'b0;
			daccfg_r      <= `CSRB_RST_DACCFG;
			edgecfg_r     <= `CSRB_RST_EDGECFG;
			vid_r         <= `CSRB_RST_VID;
			pid_r         <= `CSRB_RST_PID;
			pwrattr_r     <= `CSRB_RST_PWRATTR;
			curhalf_r     <= `CSRB_RST_CURHALF;
			inten_r       <= {`CSRB_ST_W{1'b0}};
			status_r      <= {`CSRB_ST_W{1'b0}};
			irq           <= 1'b0;
		end else if (ce) begin
			status_r <= status_nxt;
			irq      <= |(status_nxt & inten_r);
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_r     <= 1'b1;
				waddr_r       <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_r     <= 1'b1;
				wdata_r      <= s_axi_wdata;
				wstrb_r      <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (wr_go) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_err ? `CSRB_RESP_SLVERR
					: `CSRB_RESP_OKAY;
				case (waddr_r)
				`CSRB_OFF_SEC: if (wstrb_r[0]) sec_r <= wdata_r[1:0];
				`CSRB_OFF_CLKDIV: begin
					if (wstrb_r[0]) clkdiv_r <= wdata_r[4:0];
					if (wstrb_r[1]) clken_r <= wdata_r[`CSRB_CLKEN_BIT];
				end
				`CSRB_OFF_DACCFG: if (wstrb_r[0]) daccfg_r <= wdata_r[7:0];
				`CSRB_OFF_EDGECFG: if (wstrb_r[0]) begin
					edgecfg_r <= wdata_r[7:0] & `CSRB_EDGE_MASK;
				end
				`CSRB_OFF_VID: vid_r <= merge(vid_r,
					wdata_r[15:0], wstrb_r[1:0]);
				`CSRB_OFF_PID: pid_r <= merge(pid_r,
					wdata_r[15:0], wstrb_r[1:0]);
				`CSRB_OFF_PWRATTR: if (wstrb_r[0]) pwrattr_r <= wdata_r[7:0];
				`CSRB_OFF_CURHALF: if (wstrb_r[0]) curhalf_r <= wdata_r[7:0];
				`CSRB_OFF_INTEN: if (wstrb_r[0]) begin
					inten_r <= wdata_r[`CSRB_ST_W-1:0];
				end
				default: ;
				endcase
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				aw_have_r     <= 1'b0;
				w_have_r      <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	// ============================================================
	// register bus: read side
	always @* begin
		rd_err = 1'b0;
		rd_val = 32'h0000_0000;
		case (s_axi_araddr)
		`CSRB_OFF_SEC:     rd_val = {30'h0, sec_r};
		`CSRB_OFF_CLKDIV:  rd_val = {23'h0, clken_r, 3'h0, clkdiv_r};
		`CSRB_OFF_DACCFG:  rd_val = {24'h0, daccfg_r};
		`CSRB_OFF_EDGECFG: rd_val = {24'h0, edgecfg_r};
		`CSRB_OFF_VID:     rd_val = {16'h0, vid_r};
		`CSRB_OFF_PID:     rd_val = {16'h0, pid_r};
		`CSRB_OFF_PWRATTR: rd_val = {24'h0, pwrattr_r};
		`CSRB_OFF_CURHALF: rd_val = {24'h0, curhalf_r};
		`CSRB_OFF_STATUS:  rd_val = {29'h0, status_r};
		`CSRB_OFF_CLEAR:   rd_val = 32'h0000_0000;
		`CSRB_OFF_INTEN:   rd_val = {29'h0, inten_r};
		default:           rd_err = 1'b1;
		endcase
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= `CSRB_RESP_OKAY;
		end else if (ce) begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid  <= 1'b1;
				s_axi_rdata   <= rd_val;
				s_axi_rresp   <= rd_err ? `CSRB_RESP_SLVERR
					: `CSRB_RESP_OKAY;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid  <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end

endmodule

`default_nettype wire

// ---- test/csrb_props.sv ----
// checker on the report stream and the write response of the settings block
`default_nettype none
module csrb_props (
	input wire logic       aclk,
	input wire logic       aresetn,
	input wire logic       req_valid,
	input wire logic       rsp_valid,
	input wire logic [5:0] rsp_idx,
	input wire logic [7:0] rsp_data,
	input wire logic       rsp_last,
	input wire logic       s_axi_bvalid,
	input wire logic       s_axi_bready,
	input wire logic [1:0] s_axi_bresp
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	// ====================================
	// report bytes
	property p_echo;
		rsp_valid && rsp_idx == 6'h00 |-> rsp_data == 8'hB0;
	endproperty
	a_echo: assert property (p_echo) else $error("bad echo");
	property p_code;
		rsp_valid && rsp_idx == 6'h01 |-> rsp_data[7:1] == 7'h00;
	endproperty
	a_code: assert property (p_code) else $error("bad code");
	property p_div;
		rsp_valid && rsp_idx == 6'h05 |-> rsp_data[7:5] == 3'h0;
	endproperty
	a_div: assert property (p_div) else $error("byte 5 pad");
	property p_edge;
		rsp_valid && rsp_idx == 6'h07 |-> !rsp_data[7] && !rsp_data[1:0];
	endproperty
	a_edge: assert property (p_edge) else $error("byte 7 pad");
	property p_pad;
		rsp_valid && (rsp_idx == 6'h03 || rsp_idx > 6'h0D)
			|-> rsp_data == 8'h00;
	endproperty
	a_pad: assert property (p_pad) else $error("pad byte");
	// ====================================
	// framing and bus response
	property p_last;
		rsp_valid || rsp_last |-> rsp_valid && rsp_last == (rsp_idx == 6'h3F);
	endproperty
	a_last: assert property (p_last) else $error("last flag");
	property p_step;
		rsp_valid && !rsp_last
			|=> rsp_valid && rsp_idx == $past(rsp_idx) + 6'h01;
	endproperty
	a_step: assert property (p_step) else $error("byte gap");
	property p_start;
		$rose(rsp_valid) |-> rsp_idx == 6'h00 && $past(req_valid, 2);
	endproperty
	a_start: assert property (p_start) else $error("bad start");
	property p_bhold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_bhold: assert property (p_bhold) else $error("bresp dropped");
	c_last: cover property (rsp_last);
	c_unsup: cover property (rsp_valid && rsp_idx == 6'h01 && rsp_data[0]);
	c_err: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule

bind csrb_top csrb_props u_props (.aclk, .aresetn, .req_valid, .rsp_valid,
	.rsp_idx, .rsp_data, .rsp_last, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp);
`default_nettype wire

// ---- test/csrb_host.sv ----
// host model: asks for the settings report and collects the returned bytes
`default_nettype none
module csrb_host (
	input  wire logic       aclk,
	output var  logic       req_valid,
	output var  logic [7:0] req_sub,
	input  wire logic       rsp_valid,
	input  wire logic [5:0] rsp_idx,
	input  wire logic [7:0] rsp_data,
	input  wire logic       rsp_last
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] got [64];
	logic       fin = 1'b0;
	initial begin
		req_valid = 1'b0;
		req_sub = 8'h5A;
	end
	task automatic ask(input logic [7:0] s);
		@(posedge aclk);
		req_valid <= 1'b1;
		req_sub <= s;
		fin <= 1'b0;
		@(posedge aclk);
		req_valid <= 1'b0;
		// a released sub-code must not keep showing the last value
		req_sub <= ~s;
	endtask
	// raw bytes only; the bench alone decides what they mean
	always @(posedge aclk) begin
		if (rsp_valid) begin
			got[rsp_idx] <= rsp_data;
			if (rsp_last)
				fin <= 1'b1;
		end
	end
endmodule
`default_nettype wire

// ---- test/testbench.sv ----
// self-checking bench for the chip settings report builder
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        aclk = 1'b0, aresetn = 1'b0, ce = 1'b1, int_pin = 1'b0;
	logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, r;
	logic [3:0]  s_axi_wstrb = 4'hF;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic        s_axi_rvalid, req_valid, rsp_valid, rsp_last, clk_out, irq;
	logic [1:0]  s_axi_bresp, s_axi_rresp, sec;
	logic [7:0]  req_sub, rsp_data, dac, edg, pwr, cur, sub;
	logic [5:0]  rsp_idx;
	logic [4:0]  dv;
	logic [15:0] vid, pid;
	integer      seed = 32'h3002_2ba2;
	int          compares = 0, miscompares = 0, cyc = 0, n;

	always #20 aclk = ~aclk;
	csrb_top dut (.*);
	csrb_host host (.*);

	// ====================================
	// reporting
	task automatic close_out;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] s, e);
		compares++;
		if (s !== e) begin
			miscompares++;
			$display("Error %s expected %h seen %h", nm, e, s);
		end
	endtask
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			miscompares++;
			close_out;
		end
	end

	// ====================================
	// register bus master
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s, input logic [1:0] e);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end while (s_axi_awvalid | s_axi_wvalid);
		while (!s_axi_bvalid)
			@(posedge aclk);
		s_axi_bready <= 1'b0;
		chk("bresp", s_axi_bresp, e);
	endtask
	task automatic w(input logic [7:0] a, input logic [31:0] d);
		wr(a, d, 4'hF, 2'h0);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e,
		input logic [1:0] re);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
		chk("rdata", s_axi_rdata, e);
		chk("rresp", s_axi_rresp, re);
	endtask

	// ====================================
	// report expectation and check
	function automatic logic [7:0] eb(input int i);
		if (sub != 8'h00)
			return i == 0 ? 8'hB0 : {7'h00, i == 1};
		case (i)
			0: return 8'hB0;
			2: return 8'h0E;
			4: return {6'h00, sec};
			5: return {3'h0, dv};
			6: return dac;
			7: return edg & 8'h7C;
			8: return vid[7:0];
			9: return vid[15:8];
			10: return pid[7:0];
			11: return pid[15:8];
			12: return pwr;
			13: return cur;
			default: return 8'h00;
		endcase
	endfunction
	task automatic report(input logic [7:0] s);
		sub = s;
		host.ask(s);
		repeat (80) if (!host.fin) @(posedge aclk);
		chk("report done", host.fin, 1'b1);
		for (int i = 0; i < 64; i++)
			chk("report byte", host.got[i], eb(i));
	endtask
	task automatic edge_t(input logic [7:0] c, input logic p, f);
		w(8'h0C, {24'h0, c});
		w(8'h24, 32'h0000_0007);
		int_pin <= p;
		repeat (8) @(posedge aclk);
		rd(8'h20, {31'h0, f}, 2'h0);
		chk("irq", irq, f);
	endtask

	// ====================================
	// main sequence
	initial begin
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		// every register reads zero after reset, offset 0x2C is unmapped
		for (int a = 0; a < 48; a += 4)
			rd(a[7:0], 32'h0000_0000, a == 44 ? 2'h2 : 2'h0);
		wr(8'h20, 32'h0000_0007, 4'hF, 2'h2);
		wr(8'h80, 32'hFFFF_FFFF, 4'hF, 2'h2);
		for (int k = 0; k < 4; k++) begin
			r = $random(seed);
			sec = k[1:0];
			dv = r[4:0];
			dac = {k[1:0], r[13:8]};
			edg = {r[23:21], k[1:0], r[26:24]};
			vid = {r[15:8], ~r[7:0]};
			pid = r[15:0];
			pwr = r[7:0] ^ 8'hC3;
			cur = r[31:24];
			w(8'h00, {r[31:2], sec});
			w(8'h04, {r[31:9], 4'h0, dv});
			w(8'h08, {r[31:8], dac});
			w(8'h0C, {r[31:8], edg});
			w(8'h10, r);
			// one byte lane only: the high vendor byte must survive
			wr(8'h10, ~r, 4'h1, 2'h0);
			w(8'h14, {r[15:0], pid});
			w(8'h18, {r[31:8], pwr});
			w(8'h1C, {r[7:0], 16'h0000, cur});
			report(8'h00);
		end
		w(8'h24, 32'h0000_0007);
		r = $random(seed);
		report(r[7:0] | 8'h01);
		rd(8'h20, 32'h0000_0006, 2'h0);
		w(8'h28, 32'h0000_0001);
		edge_t(8'h20, 1'b1, 1'b1);
		edge_t(8'h20, 1'b0, 1'b0);
		edge_t(8'h40, 1'b1, 1'b0);
		edge_t(8'h40, 1'b0, 1'b1);
		w(8'h28, 32'h0000_0000);
		repeat (2) @(posedge aclk);
		chk("irq masked", irq, 1'b0);
		w(8'h24, 32'h0000_0007);
		rd(8'h20, 32'h0000_0000, 2'h0);
		dv = r[12:8] | 5'h01;
		w(8'h04, {23'h0, 1'b1, 3'h0, dv});
		@(posedge clk_out);
		@(posedge clk_out);
		n = 0;
		@(posedge aclk);
		while (clk_out) begin
			n++;
			@(posedge aclk);
		end
		chk("clk_out high", n, dv + 1);
		// with the enable low the running divider must not move
		ce <= 1'b0;
		n = 0;
		repeat (40) begin
			@(posedge aclk);
			if (clk_out !== 1'b0)
				n++;
		end
		ce <= 1'b1;
		chk("ce freeze", n, 0);
		close_out;
	end
endmodule
`default_nettype wire
